// ==== design/tfb_pkg.sv ====
// Constants, register map and carrier types of the trapezoid filter with baseline unit
package tfb_pkg;
    localparam int ADC_W = 14;
    localparam int DEC_W = 20;
    localparam int FIL_W = 28;
    localparam int BL_W  = 36;
    localparam int DLY_DEPTH = 128;
    localparam int DLY_AW    = 7;
    localparam int AVG_DEPTH = 256;
    localparam int AVG_AW    = 8;
    localparam int MAX_LEN_GAP    = 128;
    localparam int ADC_RATE_MHZ   = 50;
    localparam int SAMPLE_PERIOD_NS = 1000 / ADC_RATE_MHZ;

    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] LENGTH_OFS     = 8'h04;
    localparam logic [7:0] GAP_OFS        = 8'h08;
    localparam logic [7:0] BL_THRESH_OFS  = 8'h0c;
    localparam logic [7:0] INT_THRESH_OFS = 8'h10;
    localparam logic [7:0] BL_PERIOD_OFS  = 8'h14;
    localparam logic [7:0] BL_SHIFT_OFS   = 8'h18;
    localparam logic [7:0] CUT_CENTER_OFS = 8'h1c;
    localparam logic [7:0] CUT_POS_OFS    = 8'h20;
    localparam logic [7:0] CUT_NEG_OFS    = 8'h24;
    localparam logic [7:0] BL_SAMPLE_OFS  = 8'h28;
    localparam logic [7:0] STATUS_OFS     = 8'h2c;
    localparam logic [7:0] BL_AVG_OFS     = 8'h30;

    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_DEC_LSB = 1;
    localparam logic [6:0]  LENGTH_RST    = 7'h04;
    localparam logic [6:0]  GAP_RST       = 7'h03;
    localparam logic [2:0]  BL_SHIFT_RST  = 3'h5;
    localparam logic [15:0] BL_PERIOD_RST = 16'h0010;

    typedef logic signed [ADC_W-1:0] tfb_adc_t;
    typedef logic signed [DEC_W-1:0] tfb_dec_t;
    typedef logic signed [FIL_W-1:0] tfb_fil_t;
    typedef logic signed [BL_W-1:0]  tfb_bl_t;

    typedef struct packed {
        logic       enable;
        logic [1:0] dec_code;
        logic [6:0] length;
        logic [6:0] gap;
        logic [2:0] bl_shift;
    } tfb_cfg_t;

    typedef enum logic [1:0] {BL_IDLE, BL_INIT, BL_RUN} tfb_bl_state_t;
endpackage

// ==== design/tfb_delay.sv ====
// Clearable flip-flop delay line with one programmable tap
`timescale 1ns/1ps
`default_nettype none
module tfb_delay #(
    parameter int W     = 20,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                clear,
    input  wire logic                shift_en,
    input  wire logic signed [W-1:0] din,
    input  wire logic [AW-1:0]       delay,
    output logic signed [W-1:0]      dout
);
    logic signed [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0]       wp_reg;

    // Tap d gives the word written d shifts ago; d of zero gives DEPTH shifts ago
    assign dout = mem_reg[wp_reg - delay];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wp_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (clear) begin
            wp_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (shift_en) begin
            mem_reg[wp_reg] <= din;
            wp_reg          <= wp_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== design/tfb_decimator.sv ====
// Power-of-two summing decimator
`timescale 1ns/1ps
`default_nettype none
module tfb_decimator (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              clear,
    input  wire logic [2:0]        shift,
    input  wire logic              in_valid,
    input  wire tfb_pkg::tfb_adc_t in_data,
    output tfb_pkg::tfb_dec_t      out_data,
    output logic                   out_valid
);
    logic [5:0]        cnt_reg;
    logic [5:0]        mask;
    tfb_pkg::tfb_dec_t acc_reg;
    tfb_pkg::tfb_dec_t acc_next;

    assign mask     = 6'(7'h7f >> (3'h7 - shift));
    assign acc_next = acc_reg + tfb_pkg::tfb_dec_t'(in_data);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg   <= '0;
            acc_reg   <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
        end else if (clear) begin
            cnt_reg   <= '0;
            acc_reg   <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= 1'b0;
            if (in_valid) begin
                if (cnt_reg == mask) begin
                    out_data  <= acc_next;
                    out_valid <= 1'b1;
                    acc_reg   <= '0;
                    cnt_reg   <= '0;
                end else begin
                    acc_reg <= acc_next;
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end

    dec_words_a : assert property (@(posedge clock) disable iff (sys_rst)
        in_valid && !clear && cnt_reg == mask |=> out_valid && out_data == $past(acc_next))
        else $error("decimated word is not the sum of the run");
endmodule
`default_nettype wire

// ==== design/tfb_top.sv ====
// Decimated trapezoidal energy filter with baseline averaging and APB registers
// Notes on behaviour
// - step input gives trapezoid of base 2L+G
// - delays by L and L+G feed sum
// - length plus gap kept below 128
// - samples arrive at the 50 MHz rate
// - decimator sums every run of 2^N
// - decimation settings 0, 2, 4, 6
// - peaking time is length times decimation
// - decimation 0 has no intermediate filter
// - baseline sampled only below baseline threshold
// - initial mean first, then periodic samples
// - every captured sample readable for histogram; the code holds only the last capture, and a new capture overwrites it unread
// - outliers skip average, still reach histogram
// - running average subtracted from peak values
// - recursive sum with delayed sample terms
// - average count is two to shift+1
// - above decimation 0, intermediate gates baseline
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tfb_top (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              adc_valid,
    input  wire tfb_pkg::tfb_adc_t adc_data,
    input  wire logic              peak_valid,
    input  wire tfb_pkg::tfb_fil_t peak_value,
    output tfb_pkg::tfb_fil_t      filter_out,
    output logic                   filter_valid,
    output logic signed [28:0]     energy_out,
    output logic                   energy_valid
);
    ////////////////////////////////////////////////////////////////////////////
    tfb_pkg::tfb_cfg_t cfg_reg;
    tfb_pkg::tfb_cfg_t cfg_prev_reg;
    logic [31:0]       bl_thresh_reg;
    logic [31:0]       int_thresh_reg;
    logic [15:0]       bl_period_reg;
    logic [31:0]       cut_center_reg;
    logic [31:0]       cut_pos_reg;
    logic [31:0]       cut_neg_reg;
    logic              cfg_bad;
    logic              clear;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;

    function automatic logic [2:0] dec_shift(input logic [1:0] code);
        return {code, 1'b0};
    endfunction

    function automatic logic [31:0] sext32(input tfb_pkg::tfb_bl_t v);
        return v[31:0];
    endfunction

    assign cfg_bad = ({1'b0, cfg_reg.length} + {1'b0, cfg_reg.gap}) >= 8'(tfb_pkg::MAX_LEN_GAP);
    assign clear   = !cfg_reg.enable || cfg_bad || (cfg_reg != cfg_prev_reg);
    assign wr_en   = psel && penable && pready && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= tfb_pkg::BL_AVG_OFS);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg        <= '{enable: 1'b0, dec_code: 2'b00, length: tfb_pkg::LENGTH_RST,
                                gap: tfb_pkg::GAP_RST, bl_shift: tfb_pkg::BL_SHIFT_RST};
            bl_thresh_reg  <= '0;
            int_thresh_reg <= '0;
            bl_period_reg  <= tfb_pkg::BL_PERIOD_RST;
            cut_center_reg <= '0;
            cut_pos_reg    <= 32'h7fffffff;
            cut_neg_reg    <= 32'h7fffffff;
        end else if (wr_en) begin
            case (paddr)
                tfb_pkg::CTRL_OFS: begin
                    cfg_reg.enable   <= pwdata[tfb_pkg::CTRL_EN_BIT];
                    cfg_reg.dec_code <= pwdata[tfb_pkg::CTRL_DEC_LSB +: 2];
                end
                tfb_pkg::LENGTH_OFS:     cfg_reg.length   <= pwdata[6:0];
                tfb_pkg::GAP_OFS:        cfg_reg.gap      <= pwdata[6:0];
                tfb_pkg::BL_SHIFT_OFS:   cfg_reg.bl_shift <= pwdata[2:0];
                tfb_pkg::BL_THRESH_OFS:  bl_thresh_reg    <= pwdata;
                tfb_pkg::INT_THRESH_OFS: int_thresh_reg   <= pwdata;
                tfb_pkg::BL_PERIOD_OFS:  bl_period_reg    <= pwdata[15:0];
                tfb_pkg::CUT_CENTER_OFS: cut_center_reg   <= pwdata;
                tfb_pkg::CUT_POS_OFS:    cut_pos_reg      <= pwdata;
                tfb_pkg::CUT_NEG_OFS:    cut_neg_reg      <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_prev_reg <= '0;
        end else begin
            cfg_prev_reg <= cfg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decimator and trapezoid recursion
    tfb_pkg::tfb_dec_t dec_data;
    logic              dec_valid;
    tfb_pkg::tfb_dec_t v_l;
    tfb_pkg::tfb_dec_t v_lg_tap;
    tfb_pkg::tfb_dec_t v_lg;
    tfb_pkg::tfb_dec_t v_2lg;
    tfb_pkg::tfb_fil_t sum_next;
    tfb_pkg::tfb_fil_t filt_prev_reg;
    logic signed [28:0] inter_val;

    tfb_decimator u_dec (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clear     (clear),
        .shift     (dec_shift(cfg_reg.dec_code)),
        .in_valid  (adc_valid),
        .in_data   (adc_data),
        .out_data  (dec_data),
        .out_valid (dec_valid)
    );

    tfb_delay #(.W(tfb_pkg::DEC_W), .DEPTH(tfb_pkg::DLY_DEPTH), .AW(tfb_pkg::DLY_AW)) u_dly_l (
        .clock (clock), .sys_rst (sys_rst), .clear (clear), .shift_en (dec_valid),
        .din (dec_data), .delay (cfg_reg.length), .dout (v_l)
    );
    tfb_delay #(.W(tfb_pkg::DEC_W), .DEPTH(tfb_pkg::DLY_DEPTH), .AW(tfb_pkg::DLY_AW)) u_dly_g (
        .clock (clock), .sys_rst (sys_rst), .clear (clear), .shift_en (dec_valid),
        .din (v_l), .delay (cfg_reg.gap), .dout (v_lg_tap)
    );
    tfb_delay #(.W(tfb_pkg::DEC_W), .DEPTH(tfb_pkg::DLY_DEPTH), .AW(tfb_pkg::DLY_AW)) u_dly_l2 (
        .clock (clock), .sys_rst (sys_rst), .clear (clear), .shift_en (dec_valid),
        .din (v_lg), .delay (cfg_reg.length), .dout (v_2lg)
    );

    // A zero gap passes the length-delayed word straight through
    assign v_lg     = (cfg_reg.gap == 7'h00) ? v_l : v_lg_tap;
    assign sum_next = filter_out + tfb_pkg::tfb_fil_t'(dec_data) - tfb_pkg::tfb_fil_t'(v_l)
                    - tfb_pkg::tfb_fil_t'(v_lg) + tfb_pkg::tfb_fil_t'(v_2lg);
    // Intermediate filter: slope of the energy filter
    assign inter_val = 29'(filter_out) - 29'(filt_prev_reg);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            filter_out    <= '0;
            filt_prev_reg <= '0;
            filter_valid  <= 1'b0;
        end else if (clear) begin
            filter_out    <= '0;
            filt_prev_reg <= '0;
            filter_valid  <= 1'b0;
        end else begin
            filter_valid <= dec_valid;
            if (dec_valid) begin
                filter_out    <= sum_next;
                filt_prev_reg <= filter_out;
            end
        end
    end

    trap_clear_a : assert property (@(posedge clock) disable iff (sys_rst)
        clear |=> filter_out == '0 && !filter_valid)
        else $error("filter sum not cleared");
    len_limit_a : assert property (@(posedge clock) disable iff (sys_rst)
        cfg_bad |=> filter_out == '0)
        else $error("filter ran with length plus gap too large");
    sum_hold_a : assert property (@(posedge clock) disable iff (sys_rst)
        !dec_valid && !clear |=> $stable(filter_out) && !filter_valid)
        else $error("filter sum moved without a decimated sample");

    ////////////////////////////////////////////////////////////////////////////
    // Baseline capture and running average
    tfb_pkg::tfb_bl_state_t bl_state_reg;
    logic [8:0]        bl_count_reg;
    logic [15:0]       bl_tick_reg;
    logic              quiet;
    logic              bl_capture;
    logic              cut;
    logic              accept;
    logic [8:0]        avg_n;
    tfb_pkg::tfb_fil_t bl_sample_reg;
    logic              bl_new_reg;
    tfb_pkg::tfb_fil_t bl_oldest;
    tfb_pkg::tfb_bl_t  bl_sum_reg;
    tfb_pkg::tfb_bl_t  bl_dev;
    tfb_pkg::tfb_bl_t  bl_avg;

    // Shift amount is widened so that a setting of seven still gives 256
    assign avg_n = 9'h001 << ({1'b0, cfg_reg.bl_shift} + 4'h1);
    assign quiet = (cfg_reg.dec_code == 2'b00)
                 ? (32'(filter_out) < $signed(bl_thresh_reg))
                 : (32'(inter_val) < $signed(int_thresh_reg));
    assign bl_capture = filter_valid && quiet && !clear && ((bl_state_reg == tfb_pkg::BL_INIT)
                      || (bl_state_reg == tfb_pkg::BL_RUN && bl_tick_reg >= bl_period_reg));
    assign bl_dev = tfb_pkg::tfb_bl_t'(filter_out) - tfb_pkg::tfb_bl_t'($signed(cut_center_reg));
    assign cut    = (bl_dev > tfb_pkg::tfb_bl_t'($signed(cut_pos_reg)))
                 || (-bl_dev > tfb_pkg::tfb_bl_t'($signed(cut_neg_reg)));
    assign accept = bl_capture && !cut;
    assign bl_avg = bl_sum_reg >>> ({1'b0, cfg_reg.bl_shift} + 4'h1);

    tfb_delay #(.W(tfb_pkg::FIL_W), .DEPTH(tfb_pkg::AVG_DEPTH), .AW(tfb_pkg::AVG_AW)) u_bl_win (
        .clock (clock), .sys_rst (sys_rst), .clear (clear), .shift_en (accept),
        .din (filter_out), .delay (avg_n[7:0]), .dout (bl_oldest)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bl_state_reg <= tfb_pkg::BL_IDLE;
            bl_count_reg <= '0;
            bl_tick_reg  <= '0;
        end else if (clear) begin
            bl_state_reg <= tfb_pkg::BL_IDLE;
            bl_count_reg <= '0;
            bl_tick_reg  <= '0;
        end else begin
            case (bl_state_reg)
                tfb_pkg::BL_IDLE: bl_state_reg <= tfb_pkg::BL_INIT;
                tfb_pkg::BL_INIT: begin
                    if (accept) begin
                        bl_count_reg <= bl_count_reg + 9'h001;
                        if (bl_count_reg + 9'h001 >= avg_n) begin
                            bl_state_reg <= tfb_pkg::BL_RUN;
                        end
                    end
                end
                tfb_pkg::BL_RUN: begin
                    if (bl_capture) begin
                        bl_tick_reg <= '0;
                    end else if (filter_valid && bl_tick_reg != 16'hffff) begin
                        bl_tick_reg <= bl_tick_reg + 16'h0001;
                    end
                end
                default: bl_state_reg <= tfb_pkg::BL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bl_sum_reg <= '0;
        end else if (clear) begin
            bl_sum_reg <= '0;
        end else if (accept) begin
            bl_sum_reg <= bl_sum_reg + tfb_pkg::tfb_bl_t'(filter_out)
                        - tfb_pkg::tfb_bl_t'(bl_oldest);
        end
    end

    // Histogram feed: last captured sample, new flag cleared by reading it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bl_sample_reg <= '0;
            bl_new_reg    <= 1'b0;
        end else if (bl_capture) begin
            bl_sample_reg <= filter_out;
            bl_new_reg    <= 1'b1;
        end else if (rd_en && paddr == tfb_pkg::BL_SAMPLE_OFS) begin
            bl_new_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            energy_out   <= '0;
            energy_valid <= 1'b0;
        end else begin
            energy_valid <= peak_valid;
            if (peak_valid) begin
                energy_out <= 29'(peak_value) - 29'(bl_avg);
            end
        end
    end

    bl_quiet_a : assert property (@(posedge clock) disable iff (sys_rst)
        bl_capture |-> quiet && filter_valid)
        else $error("baseline captured during a pulse");
    dec0_src_a : assert property (@(posedge clock) disable iff (sys_rst)
        bl_capture && cfg_reg.dec_code == 2'b00 |-> 32'(filter_out) < $signed(bl_thresh_reg))
        else $error("decimation 0 baseline not gated by energy filter");
    bl_cut_a : assert property (@(posedge clock) disable iff (sys_rst)
        bl_capture && cut |=> $stable(bl_sum_reg) && bl_new_reg)
        else $error("cut sample entered the average or missed the histogram");
    bl_store_a : assert property (@(posedge clock) disable iff (sys_rst)
        bl_capture |=> bl_new_reg && bl_sample_reg == $past(filter_out))
        else $error("captured baseline not stored");
    energy_sub_a : assert property (@(posedge clock) disable iff (sys_rst)
        peak_valid |=> energy_valid && energy_out == 29'($past(peak_value)) - 29'($past(bl_avg)))
        else $error("energy is not peak minus baseline average");
    bl_period_a : assert property (@(posedge clock) disable iff (sys_rst)
        bl_state_reg == tfb_pkg::BL_RUN && bl_capture |-> bl_tick_reg >= bl_period_reg)
        else $error("periodic baseline taken early");

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en) begin
                case (paddr)
                    tfb_pkg::CTRL_OFS:       prdata <= {29'h0, cfg_reg.dec_code, cfg_reg.enable};
                    tfb_pkg::LENGTH_OFS:     prdata <= {25'h0, cfg_reg.length};
                    tfb_pkg::GAP_OFS:        prdata <= {25'h0, cfg_reg.gap};
                    tfb_pkg::BL_THRESH_OFS:  prdata <= bl_thresh_reg;
                    tfb_pkg::INT_THRESH_OFS: prdata <= int_thresh_reg;
                    tfb_pkg::BL_PERIOD_OFS:  prdata <= {16'h0, bl_period_reg};
                    tfb_pkg::BL_SHIFT_OFS:   prdata <= {29'h0, cfg_reg.bl_shift};
                    tfb_pkg::CUT_CENTER_OFS: prdata <= cut_center_reg;
                    tfb_pkg::CUT_POS_OFS:    prdata <= cut_pos_reg;
                    tfb_pkg::CUT_NEG_OFS:    prdata <= cut_neg_reg;
                    tfb_pkg::BL_SAMPLE_OFS:  prdata <= 32'(bl_sample_reg);
                    tfb_pkg::STATUS_OFS:     prdata <= {28'h0, cfg_bad, bl_state_reg, bl_new_reg};
                    tfb_pkg::BL_AVG_OFS:     prdata <= sext32(bl_avg);
                    default:                 prdata <= '0;
                endcase
            end
        end
    end

    apb_ready_a : assert property (@(posedge clock) disable iff (sys_rst)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb access phase not answered in one cycle");
endmodule
`default_nettype wire

// ==== bench/tfb_adc_model.sv ====
// Converter sample stream model feeding the filter
`timescale 1ns/1ps
`default_nettype none
module tfb_adc_model (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              go,
    input  wire logic [15:0]       count,
    input  wire tfb_pkg::tfb_adc_t level,
    input  wire logic              slow,
    output logic                   adc_valid,
    output tfb_pkg::tfb_adc_t      adc_data,
    output logic                   busy
);
    logic [15:0] left_reg;
    logic        skip_reg;
    assign busy = (left_reg != 16'h0000);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            left_reg  <= 16'h0000;
            skip_reg  <= 1'b0;
            adc_valid <= 1'b0;
            adc_data  <= 14'h0000;
        end else if (go) begin
            left_reg  <= count;
            adc_valid <= 1'b0;
        end else if (busy && !(slow && skip_reg)) begin
            left_reg  <= left_reg - 16'h0001;
            skip_reg  <= 1'b1;
            adc_valid <= 1'b1;
            adc_data  <= level;
        end else begin
            // Idle data toggles so nothing stale looks valid
            skip_reg  <= 1'b0;
            adc_valid <= 1'b0;
            adc_data  <= ~adc_data;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tfb_top_tb.sv ====
// Self-checking bench for the trapezoid filter with baseline unit
`timescale 1ns/1ps
`default_nettype none
module tfb_top_tb;
    logic               clock, sys_rst, psel, penable, pwrite, pready, pslverr, err_q;
    logic               go, slow, adc_valid, busy, peak_valid, filter_valid, energy_valid;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd_q;
    logic [15:0]        count;
    tfb_pkg::tfb_adc_t  level, adc_data;
    tfb_pkg::tfb_fil_t  peak_value, filter_out;
    logic signed [28:0] energy_out;
    logic signed [31:0] mon_max;
    int                 error_cnt, check_count, mon_nz, mon_words;

    tfb_top DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_data(adc_data), .peak_valid(peak_valid), .peak_value(peak_value),
        .filter_out(filter_out), .filter_valid(filter_valid), .energy_out(energy_out),
        .energy_valid(energy_valid));
    tfb_adc_model MDL (.clock(clock), .sys_rst(sys_rst), .go(go), .count(count), .level(level),
        .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (filter_valid === 1'b1) begin
            mon_words <= mon_words + 1;
            if (filter_out !== 28'h0) mon_nz <= mon_nz + 1;
            if (filter_out > mon_max) mon_max <= filter_out;
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1, "apb timeout");
            final_report();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic run(input logic [15:0] n, input logic s, input tfb_pkg::tfb_adc_t lv);
        int k;
        count <= n;
        slow  <= s;
        level <= lv;
        go    <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (busy && k < 4000);
        if (busy) begin
            check(32'h0, 32'h1, "stream timeout");
            final_report();
        end
        repeat (6) @(posedge clock);
    endtask

    task automatic trap_case(input logic [1:0] code, input logic s);
        int d;
        d = 1 << (2 * code);
        apb(1'b1, tfb_pkg::CTRL_OFS, 32'h0);
        apb(1'b1, tfb_pkg::CTRL_OFS, {29'h0, code, 1'b1});
        mon_max = 0;
        mon_nz = 0;
        mon_words = 0;
        run(16'(16 * d), s, 14'h1fff);
        check(mon_words, 32'h10, "word count");
        check(mon_nz, 2 * 5 + 3 - 1, "base width");
        check(mon_max, 5 * d * 8191, "flat top");
        $display("trapezoid at decimation code %0d done", code);
    endtask

    task automatic base_case(input logic [1:0] code, input logic [31:0] thr, input logic [31:0] ctr,
                             input logic [31:0] exp);
        apb(1'b1, tfb_pkg::CTRL_OFS, 32'h0);
        apb(1'b1, tfb_pkg::BL_THRESH_OFS, thr);
        // The other gate gets the opposite sense, so using the wrong one shows up
        apb(1'b1, tfb_pkg::INT_THRESH_OFS, -thr);
        apb(1'b1, tfb_pkg::CUT_CENTER_OFS, ctr);
        apb(1'b1, tfb_pkg::CUT_POS_OFS, 32'h0);
        apb(1'b1, tfb_pkg::CUT_NEG_OFS, 32'h0);
        apb(1'b1, tfb_pkg::CTRL_OFS, {29'h0, code, 1'b1});
        run(16'h0008, 1'b0, 14'h0000);
        apb(1'b0, tfb_pkg::STATUS_OFS, 32'h0);
        check(rd_q & 32'hf, exp, "baseline status");
        apb(1'b0, tfb_pkg::BL_SAMPLE_OFS, 32'h0);
        check(rd_q, 32'h0, "baseline sample");
        apb(1'b0, tfb_pkg::STATUS_OFS, 32'h0);
        check(rd_q & 32'h1, 32'h0, "new flag cleared");
        $display("baseline case code %0d threshold %h done", code, thr);
    endtask

    task automatic peak_case(input logic signed [27:0] pv);
        logic [31:0] avg;
        apb(1'b0, tfb_pkg::BL_AVG_OFS, 32'h0);
        avg = rd_q;
        peak_value <= pv;
        peak_valid <= 1'b1;
        @(posedge clock);
        peak_valid <= 1'b0;
        @(posedge clock);
        check({31'h0, energy_valid}, 32'h1, "energy valid");
        check(32'(energy_out), 32'(pv - $signed(avg[28:0])), "energy");
        $display("peak case done");
    endtask
    ////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, go, slow, peak_valid} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        count = 16'h0000;
        level = 14'h0000;
        peak_value = 28'h0;
        error_cnt = 0;
        check_count = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, tfb_pkg::LENGTH_OFS, 32'h0);
        check(rd_q, 32'h4, "length reset value");
        apb(1'b0, 8'h34, 32'h0);
        check({31'h0, err_q}, 32'h1, "unmapped address");
        apb(1'b1, tfb_pkg::LENGTH_OFS, 32'h5);
        apb(1'b1, tfb_pkg::GAP_OFS, 32'h3);
        apb(1'b1, tfb_pkg::BL_SHIFT_OFS, 32'h0);
        for (int c = 0; c < 4; c++) trap_case(2'(c), c == 1);
        apb(1'b1, tfb_pkg::LENGTH_OFS, 32'h64);
        apb(1'b1, tfb_pkg::GAP_OFS, 32'h1c);
        apb(1'b0, tfb_pkg::STATUS_OFS, 32'h0);
        check(rd_q & 32'h8, 32'h8, "length plus gap flag");
        mon_words = 0;
        run(16'h0040, 1'b0, 14'h1fff);
        check(mon_words, 32'h0, "refused words");
        apb(1'b1, tfb_pkg::LENGTH_OFS, 32'h5);
        base_case(2'h0, 32'h5, 32'h0, 32'h5);
        base_case(2'h0, 32'hffff_fffb, 32'h0, 32'h2);
        base_case(2'h0, 32'h5, 32'ha, 32'h3);
        base_case(2'h1, 32'hffff_fffb, 32'h0, 32'h5);
        peak_case(-28'sh4d2);
        final_report();
    end
endmodule
`default_nettype wire
